// >>> common/dtc_consts.svh
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH
// ------------------------------------------------------------
// register indices; the bus byte address is four times the index
// ------------------------------------------------------------
`define DTC_ADDR_TMODE   8'h89
`define DTC_ADDR_T0LO    8'h8A
`define DTC_ADDR_T1LO    8'h8B
`define DTC_ADDR_T0HI    8'h8C
`define DTC_ADDR_T1HI    8'h8D
`define DTC_ADDR_DIV     8'h8F
`define DTC_ADDR_T01CTL  8'h88
`define DTC_ADDR_T2CTL   8'hC8
`define DTC_ADDR_T2MODE  8'hC9
`define DTC_ADDR_CRLO    8'hCA
`define DTC_ADDR_CRHI    8'hCB
`define DTC_ADDR_T2LO    8'hCC
`define DTC_ADDR_T2HI    8'hCD
`define DTC_ADDR_SHADOW  8'hD0
// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define DTC_DIV_RESET    8'h4F
`define DTC_DIV_MASK     8'h7F
`define DTC_T2_EN_BIT    7
`define DTC_T2_CM_BIT    2
`define DTC_T2_RL_HI     4
`define DTC_T2_RL_LO     3
`define DTC_T2CTL_MASK   8'hFC
`define DTC_T2MODE_MASK  8'h07
`define DTC_T2M_CMP_OFF  3'h3
`define DTC_T2M_CMP_ON   3'h4
`define DTC_T0_RUN_BIT   4
`define DTC_T1_RUN_BIT   6
`define DTC_T0_OVF_BIT   5
`define DTC_T1_OVF_BIT   7
`define DTC_T01CTL_MASK  8'hF0
`define DTC_AXI_OKAY     2'h0
`define DTC_AXI_SLVERR   2'h2
`endif

// >>> common/dtc_pkg.sv
package dtc_pkg;
	typedef enum logic [1:0] {
		DTC_M13,
		DTC_M16,
		DTC_M8R,
		DTC_MSPLIT
	} dtc_mode_t;
endpackage

// >>> design/dtc_timers.sv
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_timers
	import dtc_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// pins
	input  wire logic        timer2_reload_trigger_pin,
	output logic             timer2_compare_output_pin
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0]  timer01_mode_select;
	logic [7:0]  timer0_count_low;
	logic [7:0]  timer1_count_low;
	logic [7:0]  timer0_count_high;
	logic [7:0]  timer1_count_high;
	logic [7:0]  timer_clock_divider;
	logic [7:0]  timer01_control;
	logic [7:0]  timer2_control;
	logic [7:0]  timer2_mode;
	logic [15:0] compare_reload;
	logic [15:0] timer2_count;
	logic        shadow_level;
	logic        compare_level;
	logic        pin_prev;
	logic [6:0]  div_cnt0;
	logic [6:0]  div_cnt1;
	logic [6:0]  div_cnt2;
	logic        tick0;
	logic        tick1;
	logic        tick2;
	// bus state
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [7:0]  w_byte;
	logic        w_lane;
	logic        wr_go;
	logic        wr_hit;

	// divider ratio from select codes, zero means reserved except timer 2 code 7, which divides by 128
	function automatic logic [6:0] ratio01(input logic [1:0] sel);
		case (sel)
			2'h1: ratio01 = 7'h04;
			2'h2: ratio01 = 7'h08;
			2'h3: ratio01 = 7'h0C;
			default: ratio01 = 7'h00;
		endcase
	endfunction

	function automatic logic [6:0] ratio2(input logic [2:0] sel);
		case (sel)
			3'h1: ratio2 = 7'h02;
			3'h2: ratio2 = 7'h04;
			3'h3: ratio2 = 7'h08;
			3'h4: ratio2 = 7'h0C;
			3'h5: ratio2 = 7'h10;
			3'h6: ratio2 = 7'h20;
			3'h7: ratio2 = 7'h00;
			default: ratio2 = 7'h00;
		endcase
	endfunction

	// register address decode
	function automatic logic mapped(input logic [7:0] a);
		case (a)
			`DTC_ADDR_TMODE, `DTC_ADDR_T0LO, `DTC_ADDR_T1LO, `DTC_ADDR_T0HI,
			`DTC_ADDR_T1HI, `DTC_ADDR_DIV, `DTC_ADDR_T01CTL, `DTC_ADDR_T2CTL,
			`DTC_ADDR_T2MODE, `DTC_ADDR_CRLO, `DTC_ADDR_CRHI, `DTC_ADDR_T2LO,
			`DTC_ADDR_T2HI, `DTC_ADDR_SHADOW: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// prescalers
	// ------------------------------------------------------------
	logic [6:0] lim0;
	logic [6:0] lim1;
	logic [6:0] lim2;
	assign lim0 = ratio01(timer_clock_divider[1:0]);
	assign lim1 = ratio01(timer_clock_divider[3:2]);
	assign lim2 = ratio2(timer_clock_divider[6:4]);

	// divide by 128 runs the full 7-bit wrap; reserved codes never tick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt0 <= 7'h00;
			div_cnt1 <= 7'h00;
			div_cnt2 <= 7'h00;
			tick0    <= 1'b0;
			tick1    <= 1'b0;
			tick2    <= 1'b0;
		end else begin
			tick0 <= 1'b0;
			tick1 <= 1'b0;
			tick2 <= 1'b0;
			if (lim0 == 7'h00 || div_cnt0 >= lim0 - 7'h01) begin
				div_cnt0 <= 7'h00;
				tick0    <= (lim0 != 7'h00);
			end else begin
				div_cnt0 <= div_cnt0 + 7'h01;
			end
			if (lim1 == 7'h00 || div_cnt1 >= lim1 - 7'h01) begin
				div_cnt1 <= 7'h00;
				tick1    <= (lim1 != 7'h00);
			end else begin
				div_cnt1 <= div_cnt1 + 7'h01;
			end
			if (timer_clock_divider[6:4] == 3'h0) begin
				div_cnt2 <= 7'h00;
			end else if (lim2 != 7'h00 && div_cnt2 >= lim2 - 7'h01) begin
				div_cnt2 <= 7'h00;
				tick2    <= 1'b1;
			end else begin
				div_cnt2 <= div_cnt2 + 7'h01;
				tick2    <= (lim2 == 7'h00) && (div_cnt2 == 7'h7F);
			end
		end
	end

	// ------------------------------------------------------------
	// axi4-lite write path
	// ------------------------------------------------------------
	assign wr_go  = aw_held && w_held && !s_axi_bvalid;
	assign wr_hit = wr_go && w_lane && mapped(aw_addr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_byte        <= 8'h00;
			w_lane        <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `DTC_AXI_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held       <= 1'b1;
				aw_addr       <= s_axi_awaddr[1:0] != 2'h0 ? 8'hFF : s_axi_awaddr[9:2];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held       <= 1'b1;
				w_byte       <= s_axi_wdata[7:0];
				w_lane       <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(aw_addr) ? `DTC_AXI_OKAY : `DTC_AXI_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer01_mode_select <= 8'h00;
			timer_clock_divider <= `DTC_DIV_RESET;
			timer2_control      <= 8'h00;
			timer2_mode         <= 8'h00;
			compare_reload      <= 16'h0000;
			shadow_level        <= 1'b0;
		end else if (wr_hit) begin
			case (aw_addr)
				`DTC_ADDR_TMODE:  timer01_mode_select <= w_byte;
				`DTC_ADDR_DIV:    timer_clock_divider <= w_byte & `DTC_DIV_MASK;
				`DTC_ADDR_T2CTL:  timer2_control <= w_byte & `DTC_T2CTL_MASK;
				`DTC_ADDR_T2MODE: timer2_mode <= w_byte & `DTC_T2MODE_MASK;
				`DTC_ADDR_CRLO:   compare_reload[7:0] <= w_byte;
				`DTC_ADDR_CRHI:   compare_reload[15:8] <= w_byte;
				`DTC_ADDR_SHADOW: shadow_level <= w_byte[0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// timer 0 and timer 1
	// ------------------------------------------------------------
	dtc_mode_t mode0;
	dtc_mode_t mode1;
	logic      run0;
	logic      run1;
	assign mode0 = dtc_mode_t'(timer01_mode_select[1:0]);
	assign mode1 = dtc_mode_t'(timer01_mode_select[5:4]);
	assign run0  = timer01_control[`DTC_T0_RUN_BIT];
	assign run1  = timer01_control[`DTC_T1_RUN_BIT];

	// counting; a software write to a count byte wins over the count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer0_count_low  <= 8'h00;
			timer0_count_high <= 8'h00;
			timer1_count_low  <= 8'h00;
			timer1_count_high <= 8'h00;
			timer01_control   <= 8'h00;
		end else begin
			// software write first, so a same-cycle hardware flag set wins
			if (wr_hit && aw_addr == `DTC_ADDR_T01CTL)
				timer01_control <= w_byte & `DTC_T01CTL_MASK;
			if (run0 && tick0) begin
				case (mode0)
					DTC_M13: begin
						timer0_count_low <= {3'h0, timer0_count_low[4:0] + 5'h01};
						if (timer0_count_low[4:0] == 5'h1F) begin
							timer0_count_high <= timer0_count_high + 8'h01;
							if (timer0_count_high == 8'hFF)
								timer01_control[`DTC_T0_OVF_BIT] <= 1'b1;
						end
					end
					DTC_M16: begin
						{timer0_count_high, timer0_count_low} <=
							{timer0_count_high, timer0_count_low} + 16'h0001;
						if ({timer0_count_high, timer0_count_low} == 16'hFFFF)
							timer01_control[`DTC_T0_OVF_BIT] <= 1'b1;
					end
					DTC_M8R: begin
						timer0_count_low <= (timer0_count_low == 8'hFF) ?
							timer0_count_high : timer0_count_low + 8'h01;
						if (timer0_count_low == 8'hFF)
							timer01_control[`DTC_T0_OVF_BIT] <= 1'b1;
					end
					DTC_MSPLIT: begin
						timer0_count_low <= timer0_count_low + 8'h01;
						if (timer0_count_low == 8'hFF)
							timer01_control[`DTC_T0_OVF_BIT] <= 1'b1;
					end
					default: ;
				endcase
			end
			// split high byte runs on timer 1 run bit and ticks
			if (mode0 == DTC_MSPLIT && run1 && tick1) begin
				timer0_count_high <= timer0_count_high + 8'h01;
				if (timer0_count_high == 8'hFF)
					timer01_control[`DTC_T1_OVF_BIT] <= 1'b1;
			end
			if (run1 && tick1) begin
				case (mode1)
					DTC_M13: begin
						timer1_count_low <= {3'h0, timer1_count_low[4:0] + 5'h01};
						if (timer1_count_low[4:0] == 5'h1F) begin
							timer1_count_high <= timer1_count_high + 8'h01;
							if (timer1_count_high == 8'hFF && mode0 != DTC_MSPLIT)
								timer01_control[`DTC_T1_OVF_BIT] <= 1'b1;
						end
					end
					DTC_M16: begin
						{timer1_count_high, timer1_count_low} <=
							{timer1_count_high, timer1_count_low} + 16'h0001;
						if ({timer1_count_high, timer1_count_low} == 16'hFFFF &&
							mode0 != DTC_MSPLIT)
							timer01_control[`DTC_T1_OVF_BIT] <= 1'b1;
					end
					DTC_M8R: begin
						timer1_count_low <= (timer1_count_low == 8'hFF) ?
							timer1_count_high : timer1_count_low + 8'h01;
						if (timer1_count_low == 8'hFF && mode0 != DTC_MSPLIT)
							timer01_control[`DTC_T1_OVF_BIT] <= 1'b1;
					end
					DTC_MSPLIT: ; // hold contents
					default: ;
				endcase
			end
			// mode 0 forces the top low bits to zero
			if (mode0 == DTC_M13)
				timer0_count_low[7:5] <= 3'h0;
			if (mode1 == DTC_M13)
				timer1_count_low[7:5] <= 3'h0;
			if (wr_hit) begin
				case (aw_addr)
					`DTC_ADDR_T0LO: timer0_count_low <= (mode0 == DTC_M13) ?
						{3'h0, w_byte[4:0]} : w_byte;
					`DTC_ADDR_T1LO: timer1_count_low <= (mode1 == DTC_M13) ?
						{3'h0, w_byte[4:0]} : w_byte;
					`DTC_ADDR_T0HI: timer0_count_high <= w_byte;
					`DTC_ADDR_T1HI: timer1_count_high <= w_byte;
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// timer 2 with reload and compare
	// ------------------------------------------------------------
	logic t2_en;
	logic t2_ovf;
	logic t2_match;
	logic pin_fall;
	logic cmp_mode;
	assign t2_en    = timer2_control[`DTC_T2_EN_BIT];
	assign t2_ovf   = t2_en && tick2 && timer2_count == 16'hFFFF;
	assign t2_match = t2_en && timer2_count == compare_reload;
	assign pin_fall = pin_prev && !timer2_reload_trigger_pin;
	assign cmp_mode = timer2_control[`DTC_T2_CM_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer2_count <= 16'h0000;
			pin_prev     <= 1'b1;
		end else begin
			pin_prev <= timer2_reload_trigger_pin;
			if (wr_hit && aw_addr == `DTC_ADDR_T2LO) begin
				timer2_count[7:0] <= w_byte;
			end else if (wr_hit && aw_addr == `DTC_ADDR_T2HI) begin
				timer2_count[15:8] <= w_byte;
			end else if (t2_en && timer2_control[`DTC_T2_RL_HI] &&
				timer2_control[`DTC_T2_RL_LO] && pin_fall) begin
				timer2_count <= compare_reload;
			end else if (t2_ovf && timer2_control[`DTC_T2_RL_HI] &&
				!timer2_control[`DTC_T2_RL_LO]) begin
				timer2_count <= compare_reload;
			end else if (t2_en && tick2) begin
				timer2_count <= timer2_count + 16'h0001;
			end
		end
	end

	// compare output level
	always_ff @(posedge aclk) begin
		if (!aresetn || !t2_en) begin
			compare_level <= 1'b0;
		end else if (!cmp_mode) begin
			if (t2_ovf)
				compare_level <= 1'b0;
			else if (t2_match)
				compare_level <= 1'b1;
		end else if (t2_match) begin
			compare_level <= shadow_level;
		end
	end

	// pin gated by the timer 2 mode field
	always_ff @(posedge aclk) begin
		if (!aresetn)
			timer2_compare_output_pin <= 1'b0;
		else
			timer2_compare_output_pin <= compare_level &&
				timer2_mode[2:0] == `DTC_T2M_CMP_ON;
	end

	// ------------------------------------------------------------
	// axi4-lite read path
	// ------------------------------------------------------------
	logic [7:0] rd_byte;
	logic       rd_ok;
	// word aligned, mapped index, nothing above the index field
	assign rd_ok = mapped(s_axi_araddr[9:2]) && s_axi_araddr[31:10] == 22'h000000 &&
		s_axi_araddr[1:0] == 2'h0;
	always_comb begin
		rd_byte = 8'h00;
		case (s_axi_araddr[9:2])
			`DTC_ADDR_TMODE:  rd_byte = timer01_mode_select;
			`DTC_ADDR_T0LO:   rd_byte = timer0_count_low;
			`DTC_ADDR_T1LO:   rd_byte = timer1_count_low;
			`DTC_ADDR_T0HI:   rd_byte = timer0_count_high;
			`DTC_ADDR_T1HI:   rd_byte = timer1_count_high;
			`DTC_ADDR_DIV:    rd_byte = timer_clock_divider;
			`DTC_ADDR_T01CTL: rd_byte = timer01_control;
			`DTC_ADDR_T2CTL:  rd_byte = timer2_control;
			`DTC_ADDR_T2MODE: rd_byte = timer2_mode;
			`DTC_ADDR_CRLO:   rd_byte = compare_reload[7:0];
			`DTC_ADDR_CRHI:   rd_byte = compare_reload[15:8];
			`DTC_ADDR_T2LO:   rd_byte = timer2_count[7:0];
			`DTC_ADDR_T2HI:   rd_byte = timer2_count[15:8];
			`DTC_ADDR_SHADOW: rd_byte = {6'h00, compare_level, shadow_level};
			default:          rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `DTC_AXI_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_ok ? {24'h000000, rd_byte} : 32'h00000000;
				s_axi_rresp   <= rd_ok ? `DTC_AXI_OKAY : `DTC_AXI_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// >>> tb/dtc_timers_chk.sv
`timescale 1ns/1ps
module dtc_timers_chk (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// write channels
	input wire logic [31:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// read channels
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// pins
	input wire logic        timer2_reload_trigger_pin,
	input wire logic        timer2_compare_output_pin
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ------------------------------------------------
	// bus handshakes and responses, compare pin at reset
	// ------------------------------------------------
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
	chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	chk_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
		&& (s_axi_rresp != 2'h2 || s_axi_rdata == 32'h0)) else $error("bad read data");
	chk_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
		else $error("bad write response");
	chk_pin_reset: assert property ($rose(aresetn) |-> !timer2_compare_output_pin)
		else $error("compare pin high after reset");
endmodule
bind dtc_timers dtc_timers_chk chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer2_reload_trigger_pin,
	.timer2_compare_output_pin);

// >>> tb/dtc_cpu_model.sv
`timescale 1ns/1ps
module dtc_cpu_model (
	// clock
	input  wire logic        aclk,
	// write channels
	output logic [31:0]      s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	// read channels
	output logic [31:0]      s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// idle bus at time zero
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// one write, address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
		logic f;
		f = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= {22'h0, a, 2'h0};
		s_axi_wdata <= {24'h0, v};
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!f) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				f = 1'b1;
			end
		end
	endtask
	// one read, data taken at the edge that shows rvalid
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic f;
		f = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= {22'h0, a, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!f) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				f = 1'b1;
			end
		end
	endtask
endmodule

// >>> tb/dtc_timers_tb_top.sv
`timescale 1ns/1ps
module dtc_timers_tb_top;
	// ------------------------------------------------
	// signals
	// ------------------------------------------------
	logic        aclk, aresetn, trig, cpo;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  v;
	integer      seed, error_cnt, n_compared, cyc, i, h, c0;
	int          dv [8] = '{0, 2, 4, 8, 12, 16, 32, 128};
	logic [7:0]  za [10] = '{8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC,
		8'hCD};
	dtc_timers dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer2_reload_trigger_pin(trig),
		.timer2_compare_output_pin(cpo));
	dtc_cpu_model cpu_u (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	// 125 MHz clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt = error_cnt + 1;
			results();
		end
	end
	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared = n_compared + 1;
		if (g !== e) begin
			error_cnt = error_cnt + 1;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] x);
		cpu_u.wr(a, x, r);
	endtask
	task rd(input logic [7:0] a);
		cpu_u.rd(a, d, r);
	endtask
	task note(input string s);
		$display("test %s done", s);
	endtask
	// tick count within one of the ideal figure
	function logic near(input logic [7:0] g, input int e);
		return (int'(g) - e) >= -1 && (int'(g) - e) <= 1;
	endfunction
	task wait_pin(input logic x);
		integer n;
		n = 0;
		while (cpo !== x && n < 300) begin
			@(posedge aclk);
			n = n + 1;
		end
		chk(32'(cpo), 32'(x));
	endtask
	task t2_setup(input logic [7:0] m, lo, hi, clo, chi, dvs);
		wr(8'hC8, 8'h00);
		wr(8'hC9, m);
		wr(8'hCA, lo);
		wr(8'hCB, hi);
		wr(8'hCC, clo);
		wr(8'hCD, chi);
		wr(8'h8F, dvs);
	endtask
	task m01(input logic [7:0] m, input logic [7:0] tl);
		wr(8'h89, m | (m << 4));
		wr(8'h8A, tl);
		wr(8'h8B, tl);
		wr(8'h8C, 8'h00);
		wr(8'h8D, 8'h00);
		wr(8'h8F, 8'h45);
		wr(8'h88, 8'h50);
		repeat (20) @(posedge aclk);
		wr(8'h88, 8'h00);
		rd(8'h8C);
		chk(d, 32'h1);
		rd(8'h8D);
		chk(d, 32'h1);
	endtask
	task cmp0(input logic [7:0] ctl, input logic [7:0] e);
		t2_setup(8'h04, 8'hF8, 8'hFF, 8'hF0, 8'hFF, 8'h1F);
		wr(8'hC8, ctl);
		wait_pin(1'b1);
		wait_pin(1'b0);
		rd(8'hCD);
		chk(d, 32'(e));
	endtask
	task rl(input logic [7:0] ctl, input logic [7:0] hi, input logic [7:0] e);
		t2_setup(8'h00, 8'h00, hi, 8'h00, 8'h00, 8'h7F);
		wr(8'hC8, ctl);
		trig <= 1'b0;
		repeat (4) @(posedge aclk);
		trig <= 1'b1;
		rd(8'hCD);
		chk(d, 32'(e));
	endtask
	task results();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		{seed, error_cnt, n_compared, cyc} = {32'd47946, 96'd0};
		aresetn = 1'b0;
		trig = 1'b1;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		chk(32'(cpo), 32'h0);
		foreach (za[k]) begin
			rd(za[k]);
			chk(d, 32'h0);
		end
		rd(8'h8F);
		chk(d, 32'h4F);
		wr(8'h8F, 8'hFF);
		rd(8'h8F);
		chk(d, 32'h7F);
		rd(8'h80);
		chk({d[29:0], r}, 32'h2);
		wr(8'h80, 8'h55);
		chk(32'(r), 32'h2);
		note("registers");
		wr(8'h89, 8'h01);
		wr(8'h8A, 8'hFF);
		wr(8'h89, 8'h00);
		rd(8'h8A);
		chk(d, 32'h1F);
		m01(8'h00, 8'h1F);
		m01(8'h01, 8'hFD);
		v = 8'($random(seed)) & 8'h7F;
		wr(8'h89, 8'h02);
		wr(8'h8C, v);
		wr(8'h8A, 8'hFE);
		wr(8'h88, 8'h10);
		repeat (30) @(posedge aclk);
		rd(8'h88);
		chk(32'(d[5]), 32'h1);
		wr(8'h88, 8'h00);
		rd(8'h8A);
		chk(32'(d[7:0] >= v), 32'h1);
		rd(8'h8C);
		chk(d, 32'(v));
		note("modes 0 1 2");
		v = 8'($random(seed));
		wr(8'h89, 8'h33);
		wr(8'h8A, 8'hF0);
		wr(8'h8C, 8'hFF);
		wr(8'h8B, v);
		wr(8'h8F, 8'h45);
		wr(8'h88, 8'h40);
		repeat (30) @(posedge aclk);
		rd(8'h88);
		chk(d, 32'hC0);
		rd(8'h8A);
		chk(d, 32'hF0);
		rd(8'h8B);
		chk(d, 32'(v));
		wr(8'h88, 8'h10);
		repeat (100) @(posedge aclk);
		rd(8'h88);
		chk(d, 32'h30);
		note("split mode");
		for (i = 0; i < 8; i = i + 1) begin
			t2_setup(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, {1'b0, 3'(i), 4'hF});
			wr(8'hC8, 8'h80);
			c0 = cyc;
			repeat (dv[i] == 0 ? 100 : dv[i] * 20) @(posedge aclk);
			wr(8'hC8, 8'h00);
			h = cyc - c0;
			rd(8'hCC);
			chk(32'(near(d[7:0], dv[i] == 0 ? 0 : h / dv[i])), 32'h1);
		end
		h = d;
		repeat (50) @(posedge aclk);
		rd(8'hCC);
		chk(d, 32'(h));
		note("timer 2 rates");
		cmp0(8'h80, 8'h00);
		cmp0(8'h90, 8'hFF);
		wr(8'hC8, 8'h00);
		repeat (2) @(posedge aclk);
		chk(32'(cpo), 32'h0);
		t2_setup(8'h03, 8'hF8, 8'hFF, 8'hF0, 8'hFF, 8'h1F);
		wr(8'hC8, 8'h80);
		h = 0;
		repeat (100) begin
			@(posedge aclk);
			h = h + cpo;
		end
		chk(h, 32'h0);
		t2_setup(8'h04, 8'hF8, 8'hFF, 8'hF0, 8'hFF, 8'h1F);
		wr(8'hD0, 8'h01);
		wr(8'hC8, 8'h94);
		wait_pin(1'b1);
		h = 0;
		repeat (80) begin
			@(posedge aclk);
			h = h + !cpo;
		end
		chk(h, 32'h0);
		wr(8'hD0, 8'h00);
		wait_pin(1'b0);
		note("compare");
		v = 8'($random(seed)) | 8'h01;
		rl(8'h98, v, v);
		rl(8'h88, v, 8'h00);
		note("reload pin");
		results();
	end
endmodule
